/* File: common/spi_flags_pkg.sv */
// Functional notes
// - Control bit 22: data writes start transfers
// - Control bit 23 empties transmit FIFO
// - Control bit 24 empties receive FIFO
// - Control bit 25 masks receive threshold interrupt
// - Control bit 26 masks receive overflow interrupt
// - Control bit 27 masks transmit underflow interrupt
// - Bit 30 set: select pin follows pin bit 3
// - Bit 31 starts counted or endless reception
// - Receive run pops and sends pending transmit data
// - Bit 31 resets to zero
// - Status 0: transfer done, write-one clears
// - Status 1: master select-input fault, write-one clears
// - Status 2: transmit FIFO reached threshold
// - Status 6: receive threshold, gated by bit 25
// - Status 7: word arrives with receive FIFO full
// - Status 8: external clock with transmit FIFO empty
// - Status 15:9: free transmit locations, 64 or 32
// - Empty 16-bit transmit FIFO reads 0100000
// - Bit 10 global enable; request holds till cleared
// - Control bit 4 selects 8 or 16 bit words
// - Bits 1:0 = 01 serial mode, 00 pins
package spi_flags_pkg;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STAT = 5'h04;
  localparam logic [4:0] OFS_DATA = 5'h08;
  localparam logic [4:0] OFS_RXCNT = 5'h0C;
  localparam logic [4:0] OFS_PIN = 5'h10;
  localparam logic [4:0] OFS_THR = 5'h14;
  localparam int B_SLAVE = 2;
  localparam int B_SIZE16 = 4;
  localparam int B_TXEN = 7;
  localparam int B_RXEN = 8;
  localparam int B_CONT = 9;
  localparam int B_IEN = 10;
  localparam int B_MDONE = 19;
  localparam int B_MFAULT = 20;
  localparam int B_MTXTH = 21;
  localparam int B_WRTRIG = 22;
  localparam int B_TXRST = 23;
  localparam int B_RXRST = 24;
  localparam int B_MRXTH = 25;
  localparam int B_MOVF = 26;
  localparam int B_MUND = 27;
  localparam int B_SSGPO = 30;
  localparam int B_RXTRIG = 31;
  localparam int S_DONE = 0;
  localparam int S_FAULT = 1;
  localparam int S_TXTH = 2;
  localparam int S_RXTH = 6;
  localparam int S_OVF = 7;
  localparam int S_UND = 8;
  localparam int RXCNT_ENDLESS = 7;
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SS = 3;
  localparam logic [1:0] MODE_SPI = 2'h1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] THR_RST = 16'h0101;
  localparam logic [6:0] DEPTH_8 = 7'h40;
  localparam logic [6:0] DEPTH_16 = 7'h20;
  localparam int CLK_NS = 5;
  localparam int SCK_HALF_NS = 40;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic {ST_IDLE, ST_XFER} xfer_state_t;
endpackage : spi_flags_pkg

/* File: core/spi_flags_core.sv */
// Design decisions made here: the Avalon-MM slave port and the register offsets.
module spi_flags_core #(
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Serial pins
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe_n,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  input wire logic i_ss_n,
  output logic o_ss_n,
  output logic o_ss_oe_n,
  // Interrupt
  output logic o_irq
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic ack_q;
  logic acc, wr_fire, rd_fire;
  logic [31:0] ctrl_q;
  logic [7:0] rxcnt_q;
  logic [7:0] pin_q;
  logic [15:0] thr_q;
  logic [8:0] st_q;
  logic [2:0] sck_s_q, sdi_s_q, ss_s_q;
  logic sck_f_q, sdi_f_q, ss_f_q;
  logic sck_rise, sck_fall;
  logic [15:0] tx_mem_q [DEPTH];
  logic [15:0] rx_mem_q [DEPTH];
  logic [5:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [6:0] tx_cnt_q, rx_cnt_q, depth, tx_free;
  logic tx_push, tx_pop, rx_push, rx_pop, rx_full;
  spi_flags_pkg::xfer_state_t state_q;
  logic [15:0] tx_sh_q, rx_sh_q;
  logic [3:0] bit_q;
  logic [7:0] div_q;
  logic sck_q, tick, rise_ev, fall_ev;
  logic spi_mode, slave, start, word_end, done_ev, run_end;
  logic [6:0] run_q;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Every access takes two edges: read data captured on the first, writes applied on the second
  assign acc = (i_read | i_write) & ~ack_q;
  assign o_waitrequest = (i_read | i_write) & ~ack_q;
  assign wr_fire = i_write & ack_q;
  assign rd_fire = i_read & ack_q;

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) ack_q <= 1'b0;
    else ack_q <= acc;
  end

  assign spi_mode = ctrl_q[1:0] == spi_flags_pkg::MODE_SPI;
  assign slave = ctrl_q[spi_flags_pkg::B_SLAVE];
  assign depth = ctrl_q[spi_flags_pkg::B_SIZE16] ? spi_flags_pkg::DEPTH_16
                                                 : spi_flags_pkg::DEPTH_8;
  assign tx_free = depth - tx_cnt_q;
  assign rx_full = rx_cnt_q >= depth;

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_readdata <= 32'h0000_0000;
    end else if (acc && i_read) begin
      if (i_address == spi_flags_pkg::OFS_CTRL) o_readdata <= ctrl_q;
      else if (i_address == spi_flags_pkg::OFS_STAT) begin
        o_readdata <= {16'h0000, tx_free, st_q};
      end else if (i_address == spi_flags_pkg::OFS_DATA) begin
        o_readdata <= {16'h0000, rx_mem_q[rx_rp_q]};
      end else if (i_address == spi_flags_pkg::OFS_RXCNT) o_readdata <= {24'h0, rxcnt_q};
      else if (i_address == spi_flags_pkg::OFS_PIN) o_readdata <= {24'h0, pin_q};
      else if (i_address == spi_flags_pkg::OFS_THR) o_readdata <= {16'h0000, thr_q};
      else o_readdata <= 32'h0000_0000;
    end
  end

  // Control word with byte enables; bit 31 drops when a counted run ends
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= spi_flags_pkg::CTRL_RST;
    end else begin
      if (wr_fire && i_address == spi_flags_pkg::OFS_CTRL) begin
        for (int b = 0; b < 4; b++) begin
          if (i_byteenable[b]) ctrl_q[b*8 +: 8] <= i_writedata[b*8 +: 8];
        end
      end else if (run_end) begin
        ctrl_q[spi_flags_pkg::B_RXTRIG] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      rxcnt_q <= 8'h00;
      pin_q <= 8'h00;
      thr_q <= spi_flags_pkg::THR_RST;
    end else if (wr_fire) begin
      if (i_address == spi_flags_pkg::OFS_RXCNT && i_byteenable[0]) begin
        rxcnt_q <= i_writedata[7:0];
      end else if (i_address == spi_flags_pkg::OFS_PIN && i_byteenable[0]) begin
        pin_q <= i_writedata[7:0];
      end else if (i_address == spi_flags_pkg::OFS_THR) begin
        if (i_byteenable[0]) thr_q[7:0] <= i_writedata[7:0];
        if (i_byteenable[1]) thr_q[15:8] <= i_writedata[15:8];
      end
    end
  end

  // Pins cross three flops; a level counts once stages two and three agree
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      sck_s_q <= 3'h0;
      sdi_s_q <= 3'h0;
      ss_s_q <= 3'h7;
      sck_f_q <= 1'b0;
      sdi_f_q <= 1'b0;
      ss_f_q <= 1'b1;
    end else begin
      sck_s_q <= {sck_s_q[1:0], i_sck};
      sdi_s_q <= {sdi_s_q[1:0], i_sdi};
      ss_s_q <= {ss_s_q[1:0], i_ss_n};
      if (sck_s_q[1] == sck_s_q[2]) sck_f_q <= sck_s_q[2];
      if (sdi_s_q[1] == sdi_s_q[2]) sdi_f_q <= sdi_s_q[2];
      if (ss_s_q[1] == ss_s_q[2]) ss_f_q <= ss_s_q[2];
    end
  end
  assign sck_rise = sck_s_q[1] == sck_s_q[2] && sck_s_q[2] && !sck_f_q;
  assign sck_fall = sck_s_q[1] == sck_s_q[2] && !sck_s_q[2] && sck_f_q;

  // Transmit FIFO, cleared and held while its reset bit is set
  assign tx_push = wr_fire && i_address == spi_flags_pkg::OFS_DATA && tx_free != 7'h00;
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp_q <= 6'h00;
      tx_rp_q <= 6'h00;
      tx_cnt_q <= 7'h00;
    end else if (ctrl_q[spi_flags_pkg::B_TXRST]) begin
      tx_wp_q <= 6'h00;
      tx_rp_q <= 6'h00;
      tx_cnt_q <= 7'h00;
    end else begin
      if (tx_push) tx_wp_q <= tx_wp_q + 6'h01;
      if (tx_pop) tx_rp_q <= tx_rp_q + 6'h01;
      if (tx_push && !tx_pop) tx_cnt_q <= tx_cnt_q + 7'h01;
      else if (tx_pop && !tx_push) tx_cnt_q <= tx_cnt_q - 7'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (tx_push) tx_mem_q[tx_wp_q] <= i_writedata[15:0];
    // Byte mode keeps only the fresh byte; the shifter still holds the previous one
    if (rx_push) begin
      rx_mem_q[rx_wp_q] <= ctrl_q[spi_flags_pkg::B_SIZE16] ? rx_sh_q : {8'h00, rx_sh_q[7:0]};
    end
  end

  // Receive FIFO; a word arriving while full is dropped
  assign rx_pop = rd_fire && i_address == spi_flags_pkg::OFS_DATA && rx_cnt_q != 7'h00;
  assign rx_push = word_end && ctrl_q[spi_flags_pkg::B_RXEN] && !rx_full;
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp_q <= 6'h00;
      rx_rp_q <= 6'h00;
      rx_cnt_q <= 7'h00;
    end else if (ctrl_q[spi_flags_pkg::B_RXRST]) begin
      rx_wp_q <= 6'h00;
      rx_rp_q <= 6'h00;
      rx_cnt_q <= 7'h00;
    end else begin
      if (rx_push) rx_wp_q <= rx_wp_q + 6'h01;
      if (rx_pop) rx_rp_q <= rx_rp_q + 6'h01;
      if (rx_push && !rx_pop) rx_cnt_q <= rx_cnt_q + 7'h01;
      else if (rx_pop && !rx_push) rx_cnt_q <= rx_cnt_q - 7'h01;
    end
  end

  // Master clock divider, running only during a word
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) div_q <= 8'h00;
    else if (state_q != spi_flags_pkg::ST_XFER || tick) div_q <= 8'h00;
    else div_q <= div_q + 8'h01;
  end
  assign tick = div_q == 8'(spi_flags_pkg::SCK_HALF_CYC - 1);
  assign rise_ev = slave ? sck_rise : (tick && !sck_q);
  assign fall_ev = slave ? sck_fall : (tick && sck_q);

  // Start: slave on select low; master on bit 31, else bit 22 with data
  always_comb begin
    start = 1'b0;
    if (state_q == spi_flags_pkg::ST_IDLE && spi_mode) begin
      if (slave) start = !ss_f_q;
      else if (ctrl_q[spi_flags_pkg::B_RXTRIG]) start = 1'b1;
      else start = ctrl_q[spi_flags_pkg::B_WRTRIG] && tx_cnt_q != 7'h00;
    end
  end
  assign tx_pop = start && tx_cnt_q != 7'h00 && !ctrl_q[spi_flags_pkg::B_TXRST];
  assign word_end = state_q == spi_flags_pkg::ST_XFER && fall_ev &&
                    bit_q == (ctrl_q[spi_flags_pkg::B_SIZE16] ? 4'hF : 4'h7);

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= spi_flags_pkg::ST_IDLE;
      tx_sh_q <= 16'h0000;
      rx_sh_q <= 16'h0000;
      bit_q <= 4'h0;
      sck_q <= 1'b0;
    end else begin
      case (state_q)
        spi_flags_pkg::ST_IDLE: begin
          sck_q <= 1'b0;
          bit_q <= 4'h0;
          if (start) begin
            state_q <= spi_flags_pkg::ST_XFER;
            if (!tx_pop) tx_sh_q <= 16'h0000;
            else if (ctrl_q[spi_flags_pkg::B_SIZE16]) tx_sh_q <= tx_mem_q[tx_rp_q];
            else tx_sh_q <= {tx_mem_q[tx_rp_q][7:0], 8'h00};
          end
        end
        spi_flags_pkg::ST_XFER: begin
          if (!spi_mode || (slave && ss_f_q)) begin
            state_q <= spi_flags_pkg::ST_IDLE;
          end else begin
            if (!slave && tick) sck_q <= !sck_q;
            if (rise_ev) rx_sh_q <= {rx_sh_q[14:0], sdi_f_q};
            if (word_end) state_q <= spi_flags_pkg::ST_IDLE;
            else if (fall_ev) begin
              tx_sh_q <= {tx_sh_q[14:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        default: state_q <= spi_flags_pkg::ST_IDLE;
      endcase
    end
  end

  // Counted receive run; bit 7 of the count word makes it endless
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) run_q <= 7'h00;
    else if (wr_fire && i_address == spi_flags_pkg::OFS_CTRL && i_byteenable[3] &&
             i_writedata[spi_flags_pkg::B_RXTRIG]) run_q <= rxcnt_q[6:0];
    else if (word_end && ctrl_q[spi_flags_pkg::B_RXTRIG] && run_q != 7'h00) begin
      run_q <= run_q - 7'h01;
    end
  end
  assign run_end = word_end && ctrl_q[spi_flags_pkg::B_RXTRIG] && !slave &&
                   !rxcnt_q[spi_flags_pkg::RXCNT_ENDLESS] && run_q <= 7'h01;

  always_comb begin
    done_ev = 1'b0;
    if (word_end) begin
      if (ctrl_q[spi_flags_pkg::B_RXTRIG] && !slave) done_ev = run_end;
      else done_ev = !ctrl_q[spi_flags_pkg::B_CONT] || tx_cnt_q == 7'h00;
    end
  end

  // Sticky flags: hardware set beats a write-one clear in the same cycle
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= 9'h000;
    end else begin
      for (int i = 0; i < 9; i++) begin
        if (wr_fire && i_address == spi_flags_pkg::OFS_STAT && i_writedata[i]) begin
          st_q[i] <= 1'b0;
        end
      end
      if (start && !slave) st_q[spi_flags_pkg::S_DONE] <= 1'b0;
      if (done_ev) st_q[spi_flags_pkg::S_DONE] <= 1'b1;
      if (spi_mode && !slave && !ctrl_q[spi_flags_pkg::B_SSGPO] && !ss_f_q) begin
        st_q[spi_flags_pkg::S_FAULT] <= 1'b1;
      end
      if (tx_cnt_q <= thr_q[6:0]) st_q[spi_flags_pkg::S_TXTH] <= 1'b1;
      if (ctrl_q[spi_flags_pkg::B_MRXTH] && rx_cnt_q >= thr_q[14:8] &&
          rx_cnt_q != 7'h00) st_q[spi_flags_pkg::S_RXTH] <= 1'b1;
      if (word_end && ctrl_q[spi_flags_pkg::B_RXEN] && ctrl_q[spi_flags_pkg::B_MOVF] &&
          rx_full) st_q[spi_flags_pkg::S_OVF] <= 1'b1;
      if (start && slave && tx_cnt_q == 7'h00 && ctrl_q[spi_flags_pkg::B_TXEN] &&
          ctrl_q[spi_flags_pkg::B_MUND]) st_q[spi_flags_pkg::S_UND] <= 1'b1;
    end
  end

  // Request holds while any unmasked cause stays set
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) o_irq <= 1'b0;
    else o_irq <= ctrl_q[spi_flags_pkg::B_IEN] &&
      ((st_q[spi_flags_pkg::S_DONE] && ctrl_q[spi_flags_pkg::B_MDONE]) ||
       (st_q[spi_flags_pkg::S_FAULT] && ctrl_q[spi_flags_pkg::B_MFAULT]) ||
       (st_q[spi_flags_pkg::S_TXTH] && ctrl_q[spi_flags_pkg::B_MTXTH]) ||
       (st_q[spi_flags_pkg::S_RXTH] && ctrl_q[spi_flags_pkg::B_MRXTH]) ||
       (st_q[spi_flags_pkg::S_OVF] && ctrl_q[spi_flags_pkg::B_MOVF]) ||
       (st_q[spi_flags_pkg::S_UND] && ctrl_q[spi_flags_pkg::B_MUND]));
  end

  // Pins; outside serial mode they follow the pin data word
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_sck <= 1'b0;
      o_sck_oe_n <= 1'b0;
      o_sdo <= 1'b0;
      o_sdo_oe_n <= 1'b0;
      o_ss_n <= 1'b1;
      o_ss_oe_n <= 1'b0;
    end else if (spi_mode) begin
      o_sck <= sck_q;
      o_sck_oe_n <= slave;
      o_sdo <= tx_sh_q[15];
      o_sdo_oe_n <= !ctrl_q[spi_flags_pkg::B_TXEN] || (slave && ss_f_q);
      o_ss_n <= pin_q[spi_flags_pkg::PIN_SS];
      o_ss_oe_n <= !ctrl_q[spi_flags_pkg::B_SSGPO];
    end else begin
      o_sck <= pin_q[spi_flags_pkg::PIN_SCK];
      o_sck_oe_n <= 1'b0;
      o_sdo <= pin_q[spi_flags_pkg::PIN_MOSI];
      o_sdo_oe_n <= 1'b0;
      o_ss_n <= pin_q[spi_flags_pkg::PIN_SS];
      o_ss_oe_n <= 1'b0;
    end
  end
endmodule : spi_flags_core

/* File: sim/spi_flags_sva.sv */
module spi_flags_sva (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_sck,
  input wire logic o_sck_oe_n,
  input wire logic o_ss_n,
  input wire logic o_ss_oe_n,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] c_q;
  logic [3:0] p_q;
  logic [1:0] age_q;
  logic rd_st;
  logic ok;
  logic [6:0] depth;
  assign ok = age_q == 2'h3;
  assign rd_st = i_read && !o_waitrequest && i_address == spi_flags_pkg::OFS_STAT;
  assign depth = c_q[4] ? spi_flags_pkg::DEPTH_16 : spi_flags_pkg::DEPTH_8;
  // Shadow words; checks wait until registered outputs catch up
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      c_q <= spi_flags_pkg::CTRL_RST;
      p_q <= 4'h0;
      age_q <= 2'h0;
    end else if (i_write && !o_waitrequest && i_address == spi_flags_pkg::OFS_CTRL) begin
      c_q <= i_writedata;
      age_q <= 2'h0;
    end else if (i_write && !o_waitrequest && i_address == spi_flags_pkg::OFS_PIN) begin
      p_q <= i_writedata[3:0];
      age_q <= 2'h0;
    end else if (!ok) begin
      age_q <= age_q + 2'h1;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_ss_gpo: assert property (ok && c_q[1:0] == 2'h1 && c_q[30] |-> !o_ss_oe_n && o_ss_n == p_q[3])
    else $error("select pin not from pin word");
  a_ss_input: assert property (ok && c_q[1:0] == 2'h1 && !c_q[30] |-> o_ss_oe_n)
    else $error("select pin driven");
  a_gpio_sck: assert property (ok && c_q[1:0] == 2'h0 |-> !o_sck_oe_n && o_sck == p_q[0])
    else $error("clock pin not from pin word");
  a_irq_global: assert property (ok && !c_q[10] |-> !o_irq)
    else $error("irq without enable");
  a_irq_masked: assert property (ok && (c_q & 32'h0E38_0000) == 32'h0 |=> !o_irq)
    else $error("irq with all masks clear");
  a_txrst_free: assert property (ok && rd_st && c_q[23] |-> o_readdata[15:9] == depth)
    else $error("free count not empty in reset");
  a_free_bound: assert property (ok && rd_st |-> o_readdata[15:9] <= depth)
    else $error("free count above depth");
  a_ctrl_back: assert property (ok && i_read && !o_waitrequest && i_address == 5'h00
    |-> o_readdata[30:0] == c_q[30:0]) else $error("control readback");
endmodule : spi_flags_sva
bind spi_flags_core spi_flags_sva u_sva (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_sck(o_sck),
  .o_sck_oe_n(o_sck_oe_n), .o_ss_n(o_ss_n), .o_ss_oe_n(o_ss_oe_n), .o_irq(o_irq));

/* File: sim/spi_peer_model.sv */
module spi_peer_model (
  input wire logic i_sck_w,
  input wire logic i_mosi,
  input wire logic i_sel,
  input wire logic [7:0] i_reply,
  output logic o_sck,
  output logic o_ss_n,
  output logic o_miso,
  output logic [7:0] o_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh_q;
  logic last_q;
  logic sel;
  assign sel = i_sel || !o_ss_n;
  // Released line shows the inverse of the last bit, never a held value
  assign o_miso = sel ? sh_q[7] : !last_q;
  initial begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_seen = 8'h00;
    last_q = 1'b0;
  end
  always @(posedge sel) sh_q <= i_reply;
  always @(posedge i_sck_w) o_seen <= {o_seen[6:0], i_mosi};
  // Reply rotates so every word repeats the same pattern
  always @(negedge i_sck_w) begin
    if (sel) begin
      last_q <= sh_q[7];
      sh_q <= {sh_q[6:0], sh_q[7]};
    end
  end
  // Clock only inside a frame, 160 ns period
  task automatic frame(input int bits);
    o_ss_n = 1'b0;
    #83;
    repeat (bits) begin
      o_sck = 1'b1;
      #80;
      o_sck = 1'b0;
      #80;
    end
    o_ss_n = 1'b1;
  endtask : frame
endmodule : spi_peer_model

/* File: sim/test_spi_trigger_and_status_flags.sv */
module test_spi_trigger_and_status_flags;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [4:0] CT = spi_flags_pkg::OFS_CTRL;
  localparam logic [4:0] ST = spi_flags_pkg::OFS_STAT;
  localparam logic [4:0] DT = spi_flags_pkg::OFS_DATA;
  logic i_clock, i_rst_n, i_read, i_write, o_waitrequest, o_sck, o_sck_oe_n, o_sdo;
  logic o_ss_n, o_ss_oe_n, o_irq, sck_w, ss_w, sdi_w, p_sck, p_ss_n, sel, o_sdo_oe_n;
  logic [4:0] i_address;
  logic [31:0] i_writedata, o_readdata;
  logic [7:0] seen;
  int errors = 0;
  int samples_checked = 0;
  assign sck_w = o_sck_oe_n ? p_sck : o_sck;
  assign ss_w = o_ss_oe_n ? p_ss_n : o_ss_n;
  spi_flags_core u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hF),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_sck(sck_w), .o_sck(o_sck),
    .o_sck_oe_n(o_sck_oe_n), .i_sdi(sdi_w), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n), .i_ss_n(ss_w),
    .o_ss_n(o_ss_n), .o_ss_oe_n(o_ss_oe_n), .o_irq(o_irq));
  spi_peer_model u_peer (.i_sck_w(sck_w), .i_mosi(o_sdo), .i_sel(sel), .i_reply(8'hA5),
    .o_sck(p_sck), .o_ss_n(p_ss_n), .o_miso(sdi_w), .o_seen(seen));
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  task automatic finish_test;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] q);
    logic done;
    int n;
    n = 0;
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= !wr;
    // Values read right at the edge are the pre-edge ones the slave sees
    do begin
      @(posedge i_clock);
      done = o_waitrequest === 1'b0;
      q = o_readdata;
      n++;
    end while (!done && n < 64);
    if (!done) errors++;
    i_write <= 1'b0;
    i_read <= 1'b0;
    @(posedge i_clock);
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic poll(input logic [4:0] a, input int b, input logic v);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0, q);
      n++;
    end while (q[b] !== v && n < 500);
    chk({31'h0, q[b]}, {31'h0, v});
  endtask : poll
  task automatic free_is(input logic [6:0] e);
    logic [31:0] q;
    bus(1'b0, ST, 32'h0, q);
    chk({25'h0, q[15:9]}, {25'h0, e});
  endtask : free_is
  task automatic t_free;
    poll(CT, 31, 1'b0);
    free_is(7'h40);
    wr(CT, 32'h0000_0181);
    repeat (3) wr(DT, 32'h0000_0055);
    repeat (40) @(posedge i_clock);
    free_is(7'h3D);
    wr(CT, 32'h0080_0181);
    wr(DT, 32'h0000_0055);
    free_is(7'h40);
    wr(CT, 32'h0000_0191);
    free_is(7'h20);
  endtask : t_free
  task automatic t_wtrig;
    logic [31:0] q;
    sel <= 1'b1;
    wr(ST, 32'h0000_0001);
    wr(CT, 32'h0040_0581);
    wr(DT, 32'h0000_003C);
    poll(ST, 0, 1'b0);
    poll(ST, 0, 1'b1);
    chk({24'h0, seen}, 32'h0000_003C);
    chk({31'h0, o_sdo_oe_n}, 32'h0);
    chk({31'h0, o_irq}, 32'h0);
    bus(1'b0, DT, 32'h0, q);
    chk(q, 32'h0000_00A5);
    wr(CT, 32'h0048_0581);
    repeat (3) @(posedge i_clock);
    chk({31'h0, o_irq}, 32'h1);
    wr(ST, 32'h0000_0001);
    repeat (3) @(posedge i_clock);
    chk({31'h0, o_irq}, 32'h0);
  endtask : t_wtrig
  task automatic t_rxtrig;
    logic [31:0] q;
    wr(CT, 32'h0200_0181);
    wr(5'h0C, 32'h0000_0002);
    wr(DT, 32'h0000_00C3);
    wr(CT, 32'h8200_0181);
    poll(CT, 31, 1'b0);
    free_is(7'h40);
    poll(ST, 6, 1'b1);
    repeat (2) begin
      bus(1'b0, DT, 32'h0, q);
      chk(q, 32'h0000_00A5);
    end
    sel <= 1'b0;
  endtask : t_rxtrig
  task automatic t_pins;
    wr(CT, 32'h4000_0001);
    for (int v = 0; v < 2; v++) begin
      wr(5'h10, 32'(v) << 3);
      repeat (3) @(posedge i_clock);
      chk({30'h0, o_ss_oe_n, o_ss_n}, 32'(v));
    end
    wr(CT, 32'h0000_0000);
    wr(5'h10, 32'h0000_0001);
    repeat (3) @(posedge i_clock);
    chk({30'h0, o_sck_oe_n, o_sck}, 32'h1);
    wr(CT, 32'h0000_0001);
    u_peer.frame(0);
    @(posedge i_clock);
    poll(ST, 1, 1'b1);
    wr(ST, 32'h0000_0002);
    poll(ST, 1, 1'b0);
  endtask : t_pins
  task automatic t_under;
    for (int m = 0; m < 2; m++) begin
      wr(ST, 32'h0000_01C7);
      wr(CT, 32'h0000_0085 | (32'(m) << 27));
      u_peer.frame(8);
      @(posedge i_clock);
      poll(ST, 8, m[0]);
    end
  endtask : t_under
  initial begin
    i_rst_n = 1'b0;
    i_address = 5'h00;
    i_read = 1'b0;
    i_write = 1'b0;
    i_writedata = 32'h0;
    sel = 1'b0;
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    wr(5'h10, 32'h0000_0000);
    t_free();
    t_wtrig();
    t_rxtrig();
    t_pins();
    t_under();
    finish_test();
  end
  initial begin
    #300000;
    errors++;
    finish_test();
  end
endmodule : test_spi_trigger_and_status_flags
